// file: core/uart_rts_line_status.sv
// register front end for rts control and line condition flags
// assumes the rest of the uart supplies fifo state on core_clk
// Notes on behaviour
// - rts bit set drives rts low
// - auto flow gates rts with rx threshold
// - rts bit clear drives rts high
// - loopback holds rts high, loops bit back
// - rx fifo error flag while errors held
// - error clears on read only when last
// - fifo mode: empty when shifter and fifo empty
// - no fifo: empty when holding and shifter empty
// - bit 5 shows holding or fifo empty
// - set whenever holding or fifo is empty, with or without a load
// - flag set raises enabled holding interrupt
// - programmable mode: flag means fifo full
// - auto flow needs fifos and enable bit
`timescale 1ns/1ps
module uart_rts_line_status
    import line_status_pkg::*;
#(
    parameter int TX_DEPTH = 16,
    parameter int LVL_W = 5
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register port
    input wire logic [31:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // uart configuration
    input wire logic fifo_en,
    input wire logic thre_mode,
    input wire logic thre_irq_en,
    input wire logic [1:0] tx_thresh,
    // receive fifo state
    input wire logic rx_above_thresh,
    input wire logic rx_err_count_nz,
    input wire logic rx_top_err,
    input wire logic rx_err_beyond_top,
    // transmit state
    input wire logic [LVL_W-1:0] tx_level,
    input wire logic holding_full,
    input wire logic shift_busy,
    input wire logic tx_load,
    input wire logic tx_write,
    // serial side
    output logic rts_n,
    output logic rts_loop,
    // interrupt
    output logic irq
);
    // ****************************************
    // parameter checks
    // ****************************************
    // the quarter threshold needs at least four entries
    if (TX_DEPTH < 4) begin
        $error("uart_rts_line_status: tx depth must be at least 4");
    end
    // the level port must count up to a full fifo
    if (LVL_W < $clog2(TX_DEPTH + 1)) begin
        $error("uart_rts_line_status: level width too small for depth");
    end
    // status and enable must fit the 16-bit register view
    if (IRQ_WIDTH > 16) begin
        $error("uart_rts_line_status: too many interrupt sources");
    end

    // ****************************************
    // registers
    // ****************************************
    logic [15:0] modem_control_reg_r;
    logic [IRQ_WIDTH-1:0] irq_status_r;
    logic [IRQ_WIDTH-1:0] irq_enable_r;
    logic rfe_r;
    logic flow_on;
    logic transmitter_empty_flag;
    logic holding_empty_flag;
    logic thre_event;
    logic txlvl_event;
    logic rfe_rise;
    logic lc_read;
    logic [15:0] line_condition_reg;
    logic [IRQ_WIDTH-1:0] irq_set;
    logic [IRQ_WIDTH-1:0] irq_status_nxt;
    logic rfe_nxt;
    logic [15:0] rdata_nxt;
    logic rts_bit;
    logic loop_bit;
    logic auto_flow_enable_bit;
    logic mc_wr;
    logic ie_wr;
    logic ic_wr;
    logic mc_rd;
    logic is_rd;
    logic ie_rd;

    function automatic logic hit(input logic [31:0] a, input logic [31:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic [15:0] widen_irq(input logic [IRQ_WIDTH-1:0] v);
        widen_irq = 16'h0000;
        widen_irq[IRQ_WIDTH-1:0] = v;
    endfunction

    // ****************************************
    // address decode
    // ****************************************
    // one strobe per register keeps the decode out of the state logic
    assign mc_wr = reg_wr && hit(reg_addr, MODEM_CTRL_OFS);
    assign ie_wr = reg_wr && hit(reg_addr, IRQ_ENABLE_OFS);
    assign ic_wr = reg_wr && hit(reg_addr, IRQ_CLEAR_OFS);
    assign mc_rd = reg_rd && hit(reg_addr, MODEM_CTRL_OFS);
    assign lc_read = reg_rd && hit(reg_addr, LINE_COND_OFS);
    assign is_rd = reg_rd && hit(reg_addr, IRQ_STATUS_OFS);
    assign ie_rd = reg_rd && hit(reg_addr, IRQ_ENABLE_OFS);

    // ****************************************
    // modem control
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            modem_control_reg_r <= MC_RESET;
        end else if (mc_wr) begin
            modem_control_reg_r <= reg_wdata & MC_WRITE_MASK;
        end
    end

    assign rts_bit = modem_control_reg_r[MC_RTS_BIT];
    assign loop_bit = modem_control_reg_r[MC_LOOP_BIT];
    assign auto_flow_enable_bit = modem_control_reg_r[MC_AUTO_FLOW_ENABLE_BIT];
    // auto flow only acts with fifos on; without them the bit is inert
    assign flow_on = fifo_en && auto_flow_enable_bit;

    // ****************************************
    // request to send
    // ****************************************
    rts_drive u_rts (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .rts_req(rts_bit),
        .loopback(loop_bit),
        .flow_on(flow_on),
        .rx_above_thresh(rx_above_thresh),
        .rts_n(rts_n),
        .rts_loop(rts_loop)
    );

    // ****************************************
    // transmitter flags
    // ****************************************
    tx_status #(
        .TX_DEPTH(TX_DEPTH),
        .LVL_W(LVL_W)
    ) u_tx (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .fifo_en(fifo_en),
        .thre_mode(thre_mode),
        .tx_thresh(tx_thresh),
        .tx_level(tx_level),
        .holding_full(holding_full),
        .shift_busy(shift_busy),
        .tx_load(tx_load),
        .tx_write(tx_write),
        .transmitter_empty_flag(transmitter_empty_flag),
        .holding_empty_flag(holding_empty_flag),
        .thre_event(thre_event),
        .txlvl_event(txlvl_event)
    );

    // ****************************************
    // receive fifo error flag
    // ****************************************
    assign rfe_rise = fifo_en && rx_err_count_nz && !rfe_r;

    // a new error in the fifo wins over a clearing read
    always_comb begin
        rfe_nxt = rfe_r;
        if (!fifo_en) begin
            rfe_nxt = 1'b0;
        end else if (rfe_rise) begin
            rfe_nxt = 1'b1;
        end else if (lc_read && rx_top_err && !rx_err_beyond_top) begin
            rfe_nxt = 1'b0;
        end else if (rx_err_count_nz) begin
            rfe_nxt = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rfe_r <= 1'b0;
        end else begin
            rfe_r <= rfe_nxt;
        end
    end

    always_comb begin
        line_condition_reg = 16'h0000;
        line_condition_reg[LC_RFE_BIT] = rfe_r;
        line_condition_reg[LC_TEMT_BIT] = transmitter_empty_flag;
        line_condition_reg[LC_THRE_BIT] = holding_empty_flag;
    end

    // ****************************************
    // interrupts
    // ****************************************
    always_comb begin
        irq_set = '0;
        irq_set[IRQ_THRE_BIT] = thre_event && thre_irq_en;
        irq_set[IRQ_TXLVL_BIT] = txlvl_event && thre_irq_en;
        irq_set[IRQ_RFE_BIT] = rfe_rise;
    end

    // set beats a same-cycle clear, so no event is lost to a late clear
    always_comb begin
        irq_status_nxt = irq_status_r;
        if (ic_wr) begin
            irq_status_nxt = irq_status_r & ~reg_wdata[IRQ_WIDTH-1:0];
        end
        irq_status_nxt = irq_status_nxt | irq_set;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status_r <= IRQ_RESET;
        end else begin
            irq_status_r <= irq_status_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_enable_r <= IRQ_RESET;
        end else if (ie_wr) begin
            irq_enable_r <= reg_wdata[IRQ_WIDTH-1:0];
        end
    end

    assign irq = |(irq_status_r & irq_enable_r);

    // ****************************************
    // read data, one cycle after the strobe
    // ****************************************
    // unmapped and write-only addresses read as zero
    always_comb begin
        rdata_nxt = 16'h0000;
        case (1'b1)
            mc_rd: rdata_nxt = modem_control_reg_r;
            lc_read: rdata_nxt = line_condition_reg;
            is_rd: rdata_nxt = widen_irq(irq_status_r);
            ie_rd: rdata_nxt = widen_irq(irq_enable_r);
            default: rdata_nxt = 16'h0000;
        endcase
    end

    // data stands one cycle only, so a stale word never reads back
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= rdata_nxt;
        end
    end
endmodule

// file: core/line_status_pkg.sv
// constants shared by the rts and line status block
// assumes a 16-bit register view reached over a plain strobe port
package line_status_pkg;
    // register offsets (byte addresses)
    localparam logic [31:0] MODEM_CTRL_OFS = 32'h5000_1010;
    localparam logic [31:0] LINE_COND_OFS = 32'h5000_1014;
    localparam logic [31:0] IRQ_STATUS_OFS = 32'h5000_1020;
    localparam logic [31:0] IRQ_ENABLE_OFS = 32'h5000_1024;
    localparam logic [31:0] IRQ_CLEAR_OFS = 32'h5000_1028;
    // modem control fields
    localparam int MC_RTS_BIT = 1;
    localparam int MC_LOOP_BIT = 4;
    localparam int MC_AUTO_FLOW_ENABLE_BIT = 5;
    localparam logic [15:0] MC_WRITE_MASK = 16'h0032;
    localparam logic [15:0] MC_RESET = 16'h0000;
    // line condition fields
    localparam int LC_THRE_BIT = 5;
    localparam int LC_TEMT_BIT = 6;
    localparam int LC_RFE_BIT = 7;
    // interrupt status fields
    localparam int IRQ_THRE_BIT = 0;
    localparam int IRQ_TXLVL_BIT = 1;
    localparam int IRQ_RFE_BIT = 2;
    localparam int IRQ_WIDTH = 3;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    // tx fifo threshold field encodings
    typedef enum logic [1:0] {
        TX_TH_EMPTY = 2'b00,
        TX_TH_TWO = 2'b01,
        TX_TH_QUARTER = 2'b10,
        TX_TH_HALF = 2'b11
    } tx_thresh_t;
endpackage

// file: core/rts_drive.sv
// request-to-send pin logic and its loopback path
// assumes all control inputs come from the same clock domain
`timescale 1ns/1ps
module rts_drive
    import line_status_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // control
    input wire logic rts_req,
    input wire logic loopback,
    input wire logic flow_on,
    input wire logic rx_above_thresh,
    // results
    output logic rts_n,
    output logic rts_loop
);
    logic assert_now;

    // rts only asserts while requested; flow control may veto it
    assign assert_now = rts_req && !(flow_on && rx_above_thresh);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rts_n <= 1'b1;
        end else begin
            rts_n <= !(assert_now && !loopback);
        end
    end

    // loopback returns the raw request bit to the modem status side
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rts_loop <= 1'b0;
        end else begin
            rts_loop <= loopback && rts_req;
        end
    end
endmodule

// file: core/tx_status.sv
// transmitter empty and holding empty flag generation
// assumes fifo levels and shift state come from the transmitter
`timescale 1ns/1ps
module tx_status
    import line_status_pkg::*;
#(
    parameter int TX_DEPTH = 16,
    parameter int LVL_W = 5
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // transmitter state
    input wire logic fifo_en,
    input wire logic thre_mode,
    input wire logic [1:0] tx_thresh,
    input wire logic [LVL_W-1:0] tx_level,
    input wire logic holding_full,
    input wire logic shift_busy,
    input wire logic tx_load,
    input wire logic tx_write,
    // flags
    output logic transmitter_empty_flag,
    output logic holding_empty_flag,
    output logic thre_event,
    output logic txlvl_event
);
    // the level port must be able to count a full fifo
    if (LVL_W < $clog2(TX_DEPTH + 1)) begin
        $error("tx_status: level width too small for depth");
    end

    logic src_empty;
    logic at_thresh;
    logic at_thresh_r;
    logic hold_empty_r;
    logic hold_empty_nxt;

    function automatic logic [LVL_W-1:0] thresh_level(input logic [1:0] sel);
        case (sel)
            TX_TH_EMPTY: thresh_level = '0;
            TX_TH_TWO: thresh_level = LVL_W'(2);
            TX_TH_QUARTER: thresh_level = LVL_W'(TX_DEPTH / 4);
            TX_TH_HALF: thresh_level = LVL_W'(TX_DEPTH / 2);
            default: thresh_level = '0;
        endcase
    endfunction

    assign src_empty = fifo_en ? (tx_level == '0) : !holding_full;
    assign at_thresh = fifo_en && thre_mode && (tx_level <= thresh_level(tx_thresh));

    // sticky empty indication: an empty source sets it, with or without a load; a new write clears it
    always_comb begin
        hold_empty_nxt = hold_empty_r;
        if (tx_write) begin
            hold_empty_nxt = 1'b0;
        end else if (tx_load && src_empty) begin
            hold_empty_nxt = 1'b1;
        end else if (src_empty) begin
            hold_empty_nxt = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_empty_r <= 1'b1;
        end else begin
            hold_empty_r <= hold_empty_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            transmitter_empty_flag <= 1'b1;
        end else begin
            transmitter_empty_flag <= src_empty && !shift_busy;
        end
    end

    // in programmable mode the flag shows a full fifo instead
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            holding_empty_flag <= 1'b1;
        end else if (fifo_en && thre_mode) begin
            holding_empty_flag <= (tx_level >= LVL_W'(TX_DEPTH));
        end else begin
            holding_empty_flag <= hold_empty_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            at_thresh_r <= 1'b0;
        end else begin
            at_thresh_r <= at_thresh;
        end
    end

    assign thre_event = !(fifo_en && thre_mode) && hold_empty_nxt && !hold_empty_r;
    assign txlvl_event = at_thresh && !at_thresh_r;
endmodule

// file: tb/uart_rts_line_status_monitor.sv
// checker for the rts and line condition block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module uart_rts_line_status_monitor
    import line_status_pkg::*;
#(
    parameter int TX_DEPTH = 16,
    parameter int LVL_W = 5
) (
    // clock, reset and register port
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [31:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // uart state
    input wire logic fifo_en,
    input wire logic thre_mode,
    input wire logic thre_irq_en,
    input wire logic rx_above_thresh,
    input wire logic [LVL_W-1:0] tx_level,
    input wire logic holding_full,
    input wire logic shift_busy,
    input wire logic tx_load,
    input wire logic tx_write,
    // outputs
    input wire logic rts_n,
    input wire logic rts_loop,
    input wire logic irq
);
    // ****************
    // shadow of software writes
    // ****************
    logic [15:0] mc_r;
    logic en_r, rd_lc, temt_x, rts_b, loop_b, auto_flow_enable_b;
    assign rd_lc = reg_rd && reg_addr == LINE_COND_OFS;
    assign temt_x = (fifo_en ? !(|tx_level) : !holding_full) && !shift_busy;
    assign rts_b = mc_r[MC_RTS_BIT];
    assign loop_b = mc_r[MC_LOOP_BIT];
    assign auto_flow_enable_b = mc_r[MC_AUTO_FLOW_ENABLE_BIT];
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mc_r <= MC_RESET;
        end else if (reg_wr && reg_addr == MODEM_CTRL_OFS) begin
            mc_r <= reg_wdata & MC_WRITE_MASK;
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_r <= 1'h0;
        end else if (reg_wr && reg_addr == IRQ_ENABLE_OFS) begin
            en_r <= reg_wdata[IRQ_THRE_BIT];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    rts_on_a:
    assert property (rts_b && !loop_b && !(auto_flow_enable_b && fifo_en && rx_above_thresh) |=> !rts_n)
        else $error("rts not asserted");
    rts_gate_a:
    assert property (rts_b && !loop_b && auto_flow_enable_b && fifo_en && rx_above_thresh |=> rts_n)
        else $error("rts not gated by rx threshold");
    rts_off_a:
    assert property (!rts_b |=> rts_n) else $error("rts asserted with bit clear");
    loop_hold_a:
    assert property (loop_b |=> rts_n && rts_loop == $past(rts_b))
        else $error("loopback rts wrong");
    rfe_off_a:
    assert property (rd_lc && !fifo_en && $stable(fifo_en) |=> !reg_rdata[LC_RFE_BIT])
        else $error("rx fifo error flag without fifo");
    resv_zero_a:
    assert property (rd_lc |=> reg_rdata[15:8] == 8'h00 && reg_rdata[4:0] == 5'h00)
        else $error("reserved line bits not zero");
    temt_flag_a:
    assert property (rd_lc && $stable(temt_x) |=> reg_rdata[LC_TEMT_BIT] == $past(temt_x))
        else $error("transmitter empty flag wrong");
    thre_irq_a:
    assert property (tx_load && !tx_write && !holding_full && $past(holding_full) && !fifo_en
        && !thre_mode && thre_irq_en && en_r |=> irq) else $error("holding irq missing");
    cover property (irq);
    cover property (rts_loop);
    cover property (rd_lc && fifo_en);
endmodule

// file: tb/modem_model.sv
// data set at the far end of the rts line
// assumes rts_n is sampled on the core clock
`timescale 1ns/1ps
module modem_model (
    // clock and serial side
    input wire logic core_clk,
    input wire logic rts_n,
    // status
    output logic may_send
);
    // sends only while the uart asks for data
    always_ff @(posedge core_clk) begin
        may_send <= !rts_n;
    end
endmodule

// file: tb/testbench.sv
// bench for the rts and line condition block
// assumes package, design, monitor and modem model compiled first
`timescale 1ns/1ps
module testbench;
    import line_status_pkg::*;
    localparam logic [31:0] LC = LINE_COND_OFS, MC = MODEM_CTRL_OFS;
    localparam logic [31:0] IS = IRQ_STATUS_OFS, IE = IRQ_ENABLE_OFS;
    logic core_clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
    logic [31:0] reg_addr = 32'h0;
    logic [15:0] reg_wdata = 16'h0, reg_rdata;
    logic fifo_en = 1'h0, thre_mode = 1'h0, thre_irq_en = 1'h0, rx_above_thresh = 1'h0;
    logic rx_err_count_nz = 1'h0, rx_top_err = 1'h0, rx_err_beyond_top = 1'h0;
    logic holding_full = 1'h0, shift_busy = 1'h0, tx_load = 1'h0, tx_write = 1'h0;
    logic [1:0] tx_thresh = 2'h0;
    logic [4:0] tx_level = 5'h0;
    logic rts_n, rts_loop, irq, may_send;
    int n_mismatch = 0, n_tests = 0;
    // rows: modem control value, then fifo, above, rts_n, loop
    logic [15:0] t_mc [6] = '{16'h0002, 16'h0002, 16'h0022, 16'h0022, 16'h0020, 16'hFFFF};
    logic [3:0] t_io [6] = '{4'h4, 4'hC, 4'hE, 4'h4, 4'hA, 4'hB};
    always #20 core_clk = ~core_clk;
    uart_rts_line_status u_dut (.*);
    modem_model u_modem (.core_clk(core_clk), .rts_n(rts_n), .may_send(may_send));
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1;
        chk("rdata", reg_rdata, exp);
        // return on an edge so callers drive their inputs there
        @(posedge core_clk);
    endtask
    task automatic pulse_write();
        @(posedge core_clk);
        tx_write <= 1'h1;
        @(posedge core_clk);
        tx_write <= 1'h0;
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ****************
    // main sequence
    // ****************
    initial begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'h1;
        repeat (2) @(posedge core_clk);
        rd(LC, 16'h0060);
        rd(MC, 16'h0000);
        foreach (t_mc[i]) begin
            wr(MC, t_mc[i]);
            fifo_en <= t_io[i][3];
            rx_above_thresh <= t_io[i][2];
            repeat (3) @(posedge core_clk);
            #1;
            chk("rts_n", {15'h0, rts_n}, {15'h0, t_io[i][1]});
            chk("rts_loop", {15'h0, rts_loop}, {15'h0, t_io[i][0]});
            chk("may_send", {15'h0, may_send}, {15'h0, ~t_io[i][1]});
        end
        rd(MC, 16'h0032);
        wr(MC, 16'h0000);
        fifo_en <= 1'h0;
        thre_irq_en <= 1'h1;
        wr(IE, 16'h0001);
        holding_full <= 1'h1;
        pulse_write();
        rd(LC, 16'h0000);
        tx_load <= 1'h1;
        holding_full <= 1'h0;
        shift_busy <= 1'h1;
        @(posedge core_clk);
        tx_load <= 1'h0;
        @(posedge core_clk);
        #1;
        chk("irq", {15'h0, irq}, 16'h0001);
        rd(LC, 16'h0020);
        rd(IS, 16'h0001);
        wr(IE, 16'h0000);
        #1;
        chk("irq masked", {15'h0, irq}, 16'h0000);
        wr(IRQ_CLEAR_OFS, 16'h0001);
        rd(IS, 16'h0000);
        shift_busy <= 1'h0;
        rd(LC, 16'h0060);
        fifo_en <= 1'h1;
        rd(LC, 16'h0060);
        tx_level <= 5'h01;
        pulse_write();
        rd(LC, 16'h0000);
        thre_mode <= 1'h1;
        tx_level <= 5'h10;
        rd(LC, 16'h0020);
        tx_thresh <= TX_TH_TWO;
        tx_level <= 5'h03;
        @(posedge core_clk);
        tx_level <= 5'h02;
        rd(IS, 16'h0002);
        rd(LC, 16'h0000);
        thre_mode <= 1'h0;
        tx_level <= 5'h00;
        rx_err_count_nz <= 1'h1;
        repeat (2) @(posedge core_clk);
        rd(LC, 16'h00E0);
        rd(LC, 16'h00E0);
        rx_top_err <= 1'h1;
        rx_err_beyond_top <= 1'h1;
        rd(LC, 16'h00E0);
        // last errored char at the top: the read shows the flag, then clears it
        rx_err_beyond_top <= 1'h0;
        rx_err_count_nz <= 1'h0;
        rd(LC, 16'h00E0);
        rd(LC, 16'h0060);
        fifo_en <= 1'h0;
        repeat (2) @(posedge core_clk);
        rd(LC, 16'h0060);
        wr(32'h5000_1030, 16'hFFFF);
        rd(32'h5000_1030, 16'h0000);
        results();
    end
    initial begin
        repeat (3000) @(posedge core_clk);
        n_mismatch++;
        results();
    end
endmodule
bind uart_rts_line_status uart_rts_line_status_monitor
    #(.TX_DEPTH(TX_DEPTH), .LVL_W(LVL_W)) u_mon (.*);
